/* File: hw/bee_pkg.sv */
package bee_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DEPTH = 256;
	// Register selects on the special function register port.
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_ADDR = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	localparam logic [1:0] SEL_UNLOCK = 2'h3;
	// Control register bit positions.
	localparam int BIT_RD = 0;
	localparam int BIT_WR = 1;
	localparam int BIT_PERMIT = 2;
	localparam int BIT_ABORT = 3;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Cycles allowed between key writes and between second key and trigger.
	localparam logic [3:0] KEY_GAP = 4'h1;
	localparam longint CLK_HZ = 25000000;
	localparam longint POWERUP_MS = 64;
	localparam longint POWERUP_CYCLES = (POWERUP_MS * CLK_HZ) / 1000;
	localparam int WRITE_CYCLES_DEFAULT = 100000;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} bee_req_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_KEY1 = 3'b010,
		ST_KEY2 = 3'b100
	} bee_unlock_t;
endpackage

/* File: hw/bee_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - 256 byte array, 8-bit address and data.
// - Byte write erases then programs automatically.
// - Internal timer ends the write cycle.
// - Protected array reads zero to programmer port.
// - Control upper four bits read zero.
// - Triggers set by software, cleared by hardware.
// - Write permit gates writes, clear at power-up.
// - Abort flag set when reset kills write.
// - Aborting reset clears address and data.
// - Write completion sets done flag; software clears.
// - Unlock port stores nothing, reads zero.
// - Read data ready the very next cycle.
// - Data register holds until read or write.
// - Write starts only after exact 55h, AAh, trigger.
// - Trigger refused without permit; permit clear harmless later.
// - Hardware never clears write permit.
// - No writes during power-up timer interval.
module bee_ctrl
	import bee_pkg::*;
#(
	parameter int WRITE_CYCLES = bee_pkg::WRITE_CYCLES_DEFAULT,
	parameter int POWERUP_CNT = int'(bee_pkg::POWERUP_CYCLES)
) (
	// Clock and power-on reset.
	input wire logic clk,
	input wire logic arst_n,
	// Warm resets, synchronous, one per source.
	input wire logic ext_reset,
	input wire logic wdog_reset,
	input wire logic brownout_reset,
	// Processor register port.
	input wire bee_pkg::bee_req_t req,
	output logic [7:0] rdata,
	// Peripheral flag register handshake.
	input wire logic done_flag_clear,
	output logic write_done_flag,
	// Programmer access port.
	input wire logic data_protect,
	input wire logic prog_rd,
	input wire logic [7:0] prog_addr,
	output logic [7:0] prog_rdata,
	// Status.
	output logic write_busy
);
	import bee_pkg::*;

	logic [7:0] mem [0:DEPTH-1];
	logic [7:0] nv_data_byte;
	logic [7:0] nv_address_byte;
	logic rd_trig;
	logic wr_trig;
	logic write_permit;
	logic write_abort_flag;
	logic [31:0] wtimer;
	logic [31:0] putimer;
	logic powered;
	bee_unlock_t ustate;
	logic [3:0] gap;
	logic [7:0] wbuf_addr;
	logic [7:0] wbuf_data;

	// One register-select decode shared by every write strobe below.
	function automatic logic sel_write(input bee_req_t r, input logic [1:0] s);
		return r.wr && r.sel == s;
	endfunction

	wire warm = ext_reset | wdog_reset | brownout_reset;
	wire wr_data = sel_write(req, SEL_DATA);
	wire wr_addr = sel_write(req, SEL_ADDR);
	wire wr_ctrl = sel_write(req, SEL_CTRL);
	wire wr_unlock = sel_write(req, SEL_UNLOCK);
	// Data, address and control writes are ignored while the write timer runs.
	wire accept = !wr_trig && !warm;
	wire unlocked = ustate == ST_KEY2 && gap <= KEY_GAP;
	wire start_wr = accept && wr_ctrl && req.wdata[BIT_WR] && write_permit
		&& unlocked && powered;
	wire start_rd = accept && wr_ctrl && req.wdata[BIT_RD];
	wire finish = wr_trig && wtimer == 32'h0;
	wire [7:0] ctrl_view = {4'h0, write_abort_flag, write_permit, wr_trig, rd_trig};
	wire [7:0] next_rdata = req.sel == SEL_DATA ? nv_data_byte :
		req.sel == SEL_ADDR ? nv_address_byte :
		req.sel == SEL_CTRL ? ctrl_view : ZERO_BYTE;

	// The array has no reset; a real cell keeps contents across power cycles.
	always_ff @(posedge clk) begin
		if (finish) begin
			mem[wbuf_addr] <= wbuf_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			putimer <= 32'h0;
			powered <= 1'b0;
		end else if (!powered) begin
			putimer <= putimer + 32'h1;
			powered <= putimer >= 32'(POWERUP_CNT - 1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nv_data_byte <= 8'h00;
			nv_address_byte <= 8'h00;
		end else if (warm && wr_trig) begin
			nv_data_byte <= 8'h00;
			nv_address_byte <= 8'h00;
		end else if (start_rd) begin
			nv_data_byte <= mem[nv_address_byte];
		end else if (accept && wr_data) begin
			nv_data_byte <= req.wdata;
		end else if (accept && wr_addr) begin
			nv_address_byte <= req.wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_trig <= 1'b0;
			wr_trig <= 1'b0;
			write_permit <= 1'b0;
			write_abort_flag <= 1'b0;
			wtimer <= 32'h0;
			wbuf_addr <= 8'h00;
			wbuf_data <= 8'h00;
		end else if (warm) begin
			// Permit survives a warm reset; only software or power-on may drop it.
			write_abort_flag <= write_abort_flag | wr_trig;
			wr_trig <= 1'b0;
			rd_trig <= 1'b0;
		end else begin
			rd_trig <= 1'b0;
			if (finish) begin
				wr_trig <= 1'b0;
			end else if (wr_trig) begin
				wtimer <= wtimer - 32'h1;
			end
			if (accept && wr_ctrl) begin
				write_permit <= req.wdata[BIT_PERMIT];
				write_abort_flag <= req.wdata[BIT_ABORT];
				rd_trig <= req.wdata[BIT_RD];
			end
			if (start_wr) begin
				wr_trig <= 1'b1;
				wtimer <= 32'(WRITE_CYCLES - 1);
				wbuf_addr <= nv_address_byte;
				wbuf_data <= nv_data_byte;
			end
		end
	end

	// Any register write other than the exact key order drops the unlock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ustate <= ST_IDLE;
			gap <= 4'h0;
		end else if (warm || (req.wr && !wr_unlock) || (wr_unlock && ustate == ST_KEY2)) begin
			ustate <= ST_IDLE;
			gap <= 4'h0;
		end else if (wr_unlock) begin
			gap <= 4'h0;
			unique case (ustate)
				ST_IDLE: ustate <= req.wdata == KEY_FIRST ? ST_KEY1 : ST_IDLE;
				ST_KEY1: ustate <= (req.wdata == KEY_SECOND && gap <= KEY_GAP)
					? ST_KEY2 : ST_IDLE;
				ST_KEY2: ustate <= ST_IDLE;
			endcase
		end else if (ustate != ST_IDLE) begin
			if (gap > KEY_GAP) begin
				ustate <= ST_IDLE;
			end else begin
				gap <= gap + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			write_done_flag <= 1'b0;
			rdata <= 8'h00;
			prog_rdata <= 8'h00;
			write_busy <= 1'b0;
		end else begin
			if (finish && !warm) begin
				write_done_flag <= 1'b1;
			end else if (done_flag_clear) begin
				write_done_flag <= 1'b0;
			end
			rdata <= req.rd ? next_rdata : ZERO_BYTE;
			prog_rdata <= (prog_rd && !data_protect) ? mem[prog_addr] : ZERO_BYTE;
			write_busy <= wr_trig && !finish;
		end
	end
endmodule

/* File: testbench/bee_props.sv */
`timescale 1ns/1ps
module bee_props (
	// Inputs of the block.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ext_reset,
	input wire logic wdog_reset,
	input wire logic brownout_reset,
	input wire bee_pkg::bee_req_t req,
	input wire logic done_flag_clear,
	input wire logic data_protect,
	input wire logic prog_rd,
	// Outputs of the block.
	input wire logic [7:0] rdata,
	input wire logic write_done_flag,
	input wire logic [7:0] prog_rdata,
	input wire logic write_busy
);
	import bee_pkg::*;
	wire logic warm = ext_reset | wdog_reset | brownout_reset;
	wire logic trig = req.wr && req.sel == SEL_CTRL && req.wdata[BIT_WR];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	unlock_zero_a: assert property ($past(req.rd && req.sel == SEL_UNLOCK) |-> !rdata)
		else $error("unlock read not zero");
	ctrl_upper_a: assert property ($past(req.rd && req.sel == SEL_CTRL) |-> !rdata[7:4])
		else $error("control upper bits set");
	prog_protect_a: assert property ($past(prog_rd && data_protect) |-> !prog_rdata)
		else $error("protected read not zero");
	done_holds_a: assert property (write_done_flag && !done_flag_clear && !warm |=> write_done_flag)
		else $error("done flag dropped");
	busy_min_a: assert property ($rose(write_busy) |-> write_busy [*8])
		else $error("write too short");
	busy_cause_a: assert property ($rose(write_busy) |-> $past(trig) || $past(trig, 2))
		else $error("write without trigger");
	done_after_a: assert property ($fell(write_busy) && !$past(warm) && !$past(warm, 2)
		|-> ##[0:2] write_done_flag) else $error("write end without done");
	cover property ($rose(write_busy));
	cover property ($rose(write_done_flag));
	cover property ($fell(write_busy) && warm);
endmodule
bind bee_ctrl bee_props u_props (.*);

/* File: testbench/bee_cpu.sv */
`timescale 1ns/1ps
module bee_cpu (
	// Clock and requests.
	input wire logic clk,
	output bee_pkg::bee_req_t req
);
	import bee_pkg::*;
	initial req = '0;
	task automatic put(input logic [1:0] s, input logic [7:0] d, input logic r);
		@(negedge clk);
		req <= '{wr: !r, rd: r, sel: s, wdata: d};
		@(negedge clk);
		req <= '0;
	endtask
	// Keys and trigger go out with one idle cycle each, inside the allowed gap.
	task automatic start(input logic [7:0] c);
		put(SEL_UNLOCK, KEY_FIRST, 1'b0);
		put(SEL_UNLOCK, KEY_SECOND, 1'b0);
		put(SEL_CTRL, c, 1'b0);
	endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import bee_pkg::*;
	logic clk = 0, arst_n = 0, ext_reset = 0, wdog_reset = 0, brownout_reset = 0;
	logic done_flag_clear = 0, data_protect = 0, prog_rd = 0, rd_d = 0;
	logic [7:0] prog_addr = '0, rdata, prog_rdata, a, d = 8'h10;
	logic write_done_flag, write_busy;
	bee_req_t req;
	logic [15:0] q[$];
	int failures = 0, checked = 0, cyc = 0;
	always #20 clk = ~clk;
	bee_cpu cpu (.clk(clk), .req(req));
	bee_ctrl #(.WRITE_CYCLES(20), .POWERUP_CNT(10)) dut (
		.clk(clk),
		.arst_n(arst_n),
		.ext_reset(ext_reset),
		.wdog_reset(wdog_reset),
		.brownout_reset(brownout_reset),
		.req(req),
		.rdata(rdata),
		.done_flag_clear(done_flag_clear),
		.write_done_flag(write_done_flag),
		.data_protect(data_protect),
		.prog_rd(prog_rd),
		.prog_addr(prog_addr),
		.prog_rdata(prog_rdata),
		.write_busy(write_busy)
	);
	function automatic logic [7:0] nx(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rd(input logic [1:0] s, input logic [7:0] m, input logic [7:0] v);
		q.push_back({m, v});
		cpu.put(s, 8'h00, 1'b1);
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (write_busy !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
	endtask
	always @(posedge clk) begin
		rd_d <= req.rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			failures++;
			test_done();
		end
	end
	// An unexpected read answer takes a note that can never match.
	always @(negedge clk) if (rd_d) begin
		if (q.size() == 0) q.push_back(16'h0001);
		cmp("rdata", q[0][7:0], rdata & q[0][15:8]);
		void'(q.pop_front());
	end
	initial begin
		repeat (8) @(negedge clk);
		arst_n = 1;
		cpu.put(SEL_CTRL, 8'h04, 1'b0);
		cpu.start(8'h06);
		settle();
		rd(SEL_CTRL, 8'h07, 8'h04);
		cpu.put(SEL_CTRL, 8'h06, 1'b0);
		rd(SEL_CTRL, 8'h07, 8'h04);
		cpu.put(SEL_CTRL, 8'h00, 1'b0);
		cpu.start(8'h02);
		rd(SEL_CTRL, 8'h07, 8'h00);
		for (int i = 0; i < 3; i++) begin
			a = nx(d);
			d = nx(a);
			cpu.put(SEL_ADDR, a, 1'b0);
			cpu.put(SEL_DATA, d, 1'b0);
			cpu.put(SEL_CTRL, 8'h04, 1'b0);
			cpu.start(8'h06);
			cpu.put(SEL_ADDR, ~a, 1'b0);
			settle();
			cmp("done", 8'h01, {7'h0, write_done_flag});
			done_flag_clear = 1;
			@(negedge clk);
			done_flag_clear = 0;
			@(negedge clk);
			cmp("done", 8'h00, {7'h0, write_done_flag});
			cpu.put(SEL_DATA, ~d, 1'b0);
			cpu.put(SEL_CTRL, 8'h05, 1'b0);
			rd(SEL_DATA, 8'hff, d);
			rd(SEL_ADDR, 8'hff, a);
			rd(SEL_CTRL, 8'h0f, 8'h04);
			rd(SEL_UNLOCK, 8'hff, 8'h00);
		end
		prog_addr = a;
		prog_rd = 1;
		@(negedge clk);
		cmp("prog_rdata", d, prog_rdata);
		data_protect = 1;
		@(negedge clk);
		cmp("prog_rdata", 8'h00, prog_rdata);
		prog_rd = 0;
		for (int k = 0; k < 3; k++) begin
			cpu.put(SEL_CTRL, 8'h04, 1'b0);
			cpu.start(8'h06);
			repeat (10) @(negedge clk);
			ext_reset = (k == 0);
			wdog_reset = (k == 1);
			brownout_reset = (k == 2);
			@(negedge clk);
			ext_reset = 0;
			wdog_reset = 0;
			brownout_reset = 0;
			settle();
			rd(SEL_CTRL, 8'h0f, 8'h0c);
			rd(SEL_ADDR, 8'hff, 8'h00);
			rd(SEL_DATA, 8'hff, 8'h00);
		end
		test_done();
	end
endmodule
